// File: core/eec_ctrl.sv
`timescale 1ns/1ps
`include "eec_map.svh"
// Contract
// RQ1: three-bit op code selects eight operations
// RQ2: operation runs only when pending is set
// RQ3: writing pending starts op, self-clears when done
// RQ4: pending high after reset until boot load
// RQ5: host waits for pending clear before reissuing
// RQ6: read puts addressed byte in data register
// RQ7: disable op sends erase/write disable instruction
// RQ8: enable op sends erase/write enable instruction
// RQ9: memory powers up with erase/write disabled
// RQ10: write stores data byte at pointer
// RQ11: write-all stores data byte everywhere
// RQ12: erase clears location at pointer
// RQ13: erase-all starts bulk erase
// RQ14: reload fails unless first byte is marker
// RQ15: failed reload changes no contents
// RQ16: load-done set on successful load
// RQ17: no response in 30 ms sets flag
// RQ18: data-in high means no time-out
// RQ19: only write and erase ops can time out
// RQ20: nine-bit byte pointer from control register
// RQ21: data register low byte, in and out
// RQ22: select, clock, data-out driven; data-in sampled
module eec_ctrl #(
    parameter int unsigned NORESP_CYCLES = `EEC_NORESP_MS * `EEC_CLK_KHZ
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic ee_select_o,
    output logic ee_clock_o,
    output logic ee_data_out_o,
    input wire logic eeprom_serial_in_i
);
    import eec_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic eeprom_op_pending_q; // busy / start bit
    eec_op_type eeprom_op_code_q; // selected operation
    logic [8:0] eeprom_byte_pointer_q; // byte address
    logic [7:0] eeprom_byte_data_q; // data register value
    logic eeprom_no_response_flag_q; // sticky time-out
    logic loaded_q; // configuration loaded
    eec_state_type st_q;
    logic [6:0] div_q; // serial clock divider
    logic [19:0] sh_q; // outgoing frame
    logic [7:0] rx_q; // incoming bits
    logic [4:0] cnt_q; // bits sent
    logic [22:0] timer_q; // no-response timer
    logic di_meta_q; // synchroniser stage one
    logic di_q; // synchroniser stage two
    logic sel_q;
    logic sk_q;
    logic do_q;
    // bus side
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    localparam logic [22:0] NORESP_LAST = 23'(NORESP_CYCLES - 1);
    // the first two polled samples still predate the reselect, so they are skipped
    wire poll_ok_w = di_q && (timer_q >= 23'd2);
    wire tick_w = (div_q == `EEC_SK_DIV - 7'd1);
    wire wr_go_w = !awready_q && !wready_q && !bvalid_q;
    wire wr_ctl_w = wr_go_w && (awaddr_q == `EEC_OFS_CONTROL);
    wire wr_dat_w = wr_go_w && (awaddr_q == `EEC_OFS_DATA);
    wire wr_bad_w = wr_go_w && !wr_ctl_w && !wr_dat_w;
    // RQ3: host start request
    wire start_w = wr_ctl_w && wstrb_q[3] && wdata_q[`EEC_PEND_BIT] && !eeprom_op_pending_q;
    // RQ17: software clear, one written to the flag
    wire clr_to_w = wr_ctl_w && wstrb_q[1] && wdata_q[`EEC_NORESP_BIT];
    wire [31:0] ctl_view_w = {eeprom_op_pending_q, eeprom_op_code_q, 17'h00000,
        eeprom_no_response_flag_q, loaded_q, eeprom_byte_pointer_q};
    wire rd_ctl_w = (s_axi_araddr_i == `EEC_OFS_CONTROL);
    wire rd_dat_w = (s_axi_araddr_i == `EEC_OFS_DATA);
    wire [31:0] rd_mux_w = rd_ctl_w ? ctl_view_w : (rd_dat_w ? {24'h000000, eeprom_byte_data_q} : 32'h00000000);

    // ------------------------------------------------------------
    // frame builder
    // ------------------------------------------------------------
    logic [1:0] ser_op_w;
    logic [8:0] ser_adr_w;
    logic [7:0] ser_dat_w;
    logic [4:0] len_w;
    logic wait_w; // needs a ready poll afterwards
    // RQ1: op code decode
    always_comb begin
        ser_op_w = `EEC_SER_MISC;
        ser_adr_w = eeprom_byte_pointer_q;
        ser_dat_w = 8'h00;
        len_w = `EEC_LEN_SHORT;
        wait_w = 1'b0;
        unique case (eeprom_op_code_q)
            // RQ6: read at pointer
            EEC_OP_READ: begin
                ser_op_w = `EEC_SER_READ;
                len_w = `EEC_LEN_LONG;
            end
            // RQ7: disable instruction
            EEC_OP_ERASE_WRITE_DISABLE: begin
                ser_adr_w = `EEC_ADR_ERASE_WRITE_DISABLE;
            end
            // RQ8: enable instruction
            EEC_OP_ERASE_WRITE_ENABLE: begin
                ser_adr_w = `EEC_ADR_ERASE_WRITE_ENABLE;
            end
            // RQ10: store data byte
            EEC_OP_WRITE: begin
                ser_op_w = `EEC_SER_WRITE;
                ser_dat_w = eeprom_byte_data_q;
                len_w = `EEC_LEN_LONG;
                wait_w = 1'b1;
            end
            // RQ11: store everywhere
            EEC_OP_WRITE_ALL_LOCATIONS: begin
                ser_adr_w = `EEC_ADR_WRITE_ALL_LOCATIONS;
                ser_dat_w = eeprom_byte_data_q;
                len_w = `EEC_LEN_LONG;
                wait_w = 1'b1;
            end
            // RQ12: erase one location
            EEC_OP_ERASE: begin
                ser_op_w = `EEC_SER_ERASE;
                wait_w = 1'b1;
            end
            // RQ13: bulk erase
            EEC_OP_ERASE_ALL_LOCATIONS: begin
                ser_adr_w = `EEC_ADR_ERASE_ALL_LOCATIONS;
                wait_w = 1'b1;
            end
            // RQ14: reload reads the marker byte
            EEC_OP_RELOAD: begin
                ser_op_w = `EEC_SER_READ;
                ser_adr_w = `EEC_RST_PTR;
                len_w = `EEC_LEN_LONG;
            end
        endcase
    end
    // RQ22: start bit, opcode, address, then data
    wire [19:0] frame_w = {1'b1, ser_op_w, ser_adr_w, ser_dat_w};
    wire last_bit_w = (cnt_q + 5'd1 == len_w);
    wire reload_ok_w = (rx_q == `EEC_MARKER);

    // ------------------------------------------------------------
    // synchroniser and divider
    // ------------------------------------------------------------
    // data-in comes from a pin, so two flops before any use
    always_ff @(posedge clk_i) begin
        di_meta_q <= eeprom_serial_in_i;
        di_q <= di_meta_q;
    end

    // serial clock enable, runs free
    always_ff @(posedge clk_i) begin
        if (reset_i || tick_w) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'd1;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // frame shifts out on the falling serial clock, samples in on the same edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= EEC_ST_IDLE;
            sel_q <= 1'b0;
            sk_q <= 1'b0;
            do_q <= 1'b0;
            sh_q <= 20'h00000;
            rx_q <= 8'h00;
            cnt_q <= 5'h00;
            timer_q <= 23'h000000;
        end else begin
            unique case (st_q)
                // RQ2: leave idle only while pending
                EEC_ST_IDLE: begin
                    if (eeprom_op_pending_q && tick_w) begin
                        st_q <= EEC_ST_SELECT;
                    end
                end
                // raise select and present the first bit
                EEC_ST_SELECT: begin
                    sel_q <= 1'b1;
                    do_q <= frame_w[19];
                    sh_q <= {frame_w[18:0], 1'b0};
                    cnt_q <= 5'h00;
                    st_q <= EEC_ST_SHIFT;
                end
                // RQ22: clock the frame through
                EEC_ST_SHIFT: begin
                    if (tick_w) begin
                        sk_q <= !sk_q;
                        if (sk_q) begin
                            rx_q <= {rx_q[6:0], di_q};
                            do_q <= sh_q[19];
                            sh_q <= {sh_q[18:0], 1'b0};
                            cnt_q <= cnt_q + 5'd1;
                            if (last_bit_w) begin
                                st_q <= EEC_ST_END;
                            end
                        end
                    end
                end
                // drop select; only writes and erases poll for ready
                EEC_ST_END: begin
                    if (tick_w) begin
                        sel_q <= 1'b0;
                        do_q <= 1'b0;
                        // RQ19: reads and enables never poll
                        st_q <= wait_w ? EEC_ST_RDY_SEL : EEC_ST_IDLE;
                    end
                end
                // reselect so the part reports ready on data-in
                EEC_ST_RDY_SEL: begin
                    if (tick_w) begin
                        sel_q <= 1'b1;
                        timer_q <= 23'h000000;
                        st_q <= EEC_ST_RDY_WAIT;
                    end
                end
                // RQ18: data-in high ends the wait at once
                EEC_ST_RDY_WAIT: begin
                    timer_q <= timer_q + 23'd1;
                    if (poll_ok_w || timer_q == NORESP_LAST) begin
                        sel_q <= 1'b0;
                        st_q <= EEC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    wire seq_done_w = (st_q == EEC_ST_END && tick_w && !wait_w) || (st_q == EEC_ST_RDY_WAIT && poll_ok_w);
    wire seq_tout_w = (st_q == EEC_ST_RDY_WAIT && !poll_ok_w && timer_q == NORESP_LAST);

    // ------------------------------------------------------------
    // control and data registers
    // ------------------------------------------------------------
    // RQ4: pending high from reset, boot runs a reload
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eeprom_op_pending_q <= 1'b1;
            eeprom_op_code_q <= EEC_OP_RELOAD;
            eeprom_byte_pointer_q <= `EEC_RST_PTR;
        end else begin
            // RQ3: self-clear on completion or time-out
            if (seq_done_w || seq_tout_w) begin
                eeprom_op_pending_q <= 1'b0;
            end else if (start_w) begin
                eeprom_op_pending_q <= 1'b1;
            end
            // fields are frozen while busy, guarding a misbehaving host
            if (wr_ctl_w && !eeprom_op_pending_q) begin
                if (wstrb_q[3]) begin
                    eeprom_op_code_q <= eec_op_type'(wdata_q[`EEC_OP_HI:`EEC_OP_LO]);
                end
                // RQ20: nine-bit byte pointer
                if (wstrb_q[1]) begin
                    eeprom_byte_pointer_q[8] <= wdata_q[`EEC_PTR_HI];
                end
                if (wstrb_q[0]) begin
                    eeprom_byte_pointer_q[7:0] <= wdata_q[7:0];
                end
            end
        end
    end

    // RQ21: data byte, host written or read result
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eeprom_byte_data_q <= `EEC_RST_DATA;
        end else if (seq_done_w && eeprom_op_code_q == EEC_OP_READ) begin
            eeprom_byte_data_q <= rx_q;
        end else if (wr_dat_w && wstrb_q[0] && !eeprom_op_pending_q) begin
            eeprom_byte_data_q <= wdata_q[7:0];
        end
    end

    // RQ16: loaded only on a marker match; RQ15: a miss leaves it alone
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            loaded_q <= 1'b0;
        end else if (seq_done_w && eeprom_op_code_q == EEC_OP_RELOAD && reload_ok_w) begin
            loaded_q <= 1'b1;
        end
    end

    // RQ17: sticky flag, a new time-out beats a clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eeprom_no_response_flag_q <= 1'b0;
        end else if (seq_tout_w) begin
            eeprom_no_response_flag_q <= 1'b1;
        end else if (clr_to_w) begin
            eeprom_no_response_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bus slave, write path
    // ------------------------------------------------------------
    // address and data are taken in either order, one write at a time
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (awready_q && s_axi_awvalid_i) begin
                awready_q <= 1'b0;
                awaddr_q <= {s_axi_awaddr_i[11:2], 2'h0};
            end
            if (wready_q && s_axi_wvalid_i) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            // unmapped addresses answer with a slave error
            if (wr_go_w) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_bad_w ? 2'h2 : 2'h0;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // bus slave, read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end else if (arready_q && s_axi_arvalid_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux_w;
            rresp_q <= (rd_ctl_w || rd_dat_w) ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign ee_select_o = sel_q;
    assign ee_clock_o = sk_q;
    assign ee_data_out_o = do_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_boot_pending;
        $fell(reset_i) |-> eeprom_op_pending_q && eeprom_op_code_q == EEC_OP_RELOAD;
    endproperty
    a_boot_pending: assert property (p_boot_pending) else $error("pending low after reset"); // RQ4

    property p_idle_holds;
        (st_q == EEC_ST_IDLE && !eeprom_op_pending_q) |=> st_q == EEC_ST_IDLE;
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("sequencer left idle without pending"); // RQ2

    property p_start_sets;
        start_w |=> eeprom_op_pending_q ##1 st_q != EEC_ST_SHIFT || eeprom_op_pending_q;
    endproperty
    a_start_sets: assert property (p_start_sets) else $error("start did not set pending"); // RQ3

    sequence s_tout;
        seq_tout_w;
    endsequence
    property p_tout;
        s_tout |=> eeprom_no_response_flag_q && !eeprom_op_pending_q && st_q == EEC_ST_IDLE && !sel_q;
    endproperty
    a_tout: assert property (p_tout) else $error("time-out not reported"); // RQ17

    property p_ready_high;
        (st_q == EEC_ST_RDY_WAIT && poll_ok_w) |=> st_q == EEC_ST_IDLE && !eeprom_op_pending_q
            && $stable(eeprom_no_response_flag_q);
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready poll did not finish"); // RQ18

    property p_no_wait_read;
        (st_q == EEC_ST_END && (eeprom_op_code_q == EEC_OP_READ || eeprom_op_code_q == EEC_OP_RELOAD))
            |=> st_q != EEC_ST_RDY_SEL;
    endproperty
    a_no_wait_read: assert property (p_no_wait_read) else $error("read entered ready poll"); // RQ19

    property p_read_data;
        (seq_done_w && eeprom_op_code_q == EEC_OP_READ) |=> eeprom_byte_data_q == $past(rx_q);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read result not stored"); // RQ6

    property p_reload_good;
        (seq_done_w && eeprom_op_code_q == EEC_OP_RELOAD && rx_q == `EEC_MARKER) |=> loaded_q;
    endproperty
    a_reload_good: assert property (p_reload_good) else $error("good reload not flagged"); // RQ16

    property p_reload_bad;
        (seq_done_w && eeprom_op_code_q == EEC_OP_RELOAD && rx_q != `EEC_MARKER)
            |=> $stable(loaded_q) && $stable(eeprom_byte_data_q);
    endproperty
    a_reload_bad: assert property (p_reload_bad) else $error("failed reload changed state"); // RQ15

    property p_select_idle;
        st_q == EEC_ST_IDLE |-> !sel_q && !sk_q;
    endproperty
    a_select_idle: assert property (p_select_idle) else $error("select or clock active in idle"); // RQ22

endmodule

// File: inc/eec_map.svh
`ifndef EEC_MAP_SVH
`define EEC_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define EEC_OFS_CONTROL 12'h030
`define EEC_OFS_DATA 12'h034

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define EEC_PEND_BIT 31
`define EEC_OP_HI 30
`define EEC_OP_LO 28
`define EEC_NORESP_BIT 10
`define EEC_LOADED_BIT 9
`define EEC_PTR_HI 8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define EEC_RST_PTR 9'h000
`define EEC_RST_DATA 8'h00

// ------------------------------------------------------------
// serial framing
// ------------------------------------------------------------
`define EEC_MARKER 8'hA5
`define EEC_SER_READ 2'h2
`define EEC_SER_WRITE 2'h1
`define EEC_SER_ERASE 2'h3
`define EEC_SER_MISC 2'h0
`define EEC_ADR_ERASE_WRITE_ENABLE 9'h180
`define EEC_ADR_ERASE_WRITE_DISABLE 9'h000
`define EEC_ADR_WRITE_ALL_LOCATIONS 9'h080
`define EEC_ADR_ERASE_ALL_LOCATIONS 9'h100
`define EEC_LEN_SHORT 5'd12
`define EEC_LEN_LONG 5'd20

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EEC_CLK_KHZ 200000
`define EEC_NORESP_MS 30
`define EEC_SK_DIV 7'd100

`endif

// File: inc/eec_pkg.sv
package eec_pkg;
    // operation codes as held in the control register
    typedef enum logic [2:0] {
        EEC_OP_READ = 3'h0,
        EEC_OP_ERASE_WRITE_DISABLE = 3'h1,
        EEC_OP_ERASE_WRITE_ENABLE = 3'h2,
        EEC_OP_WRITE = 3'h3,
        EEC_OP_WRITE_ALL_LOCATIONS = 3'h4,
        EEC_OP_ERASE = 3'h5,
        EEC_OP_ERASE_ALL_LOCATIONS = 3'h6,
        EEC_OP_RELOAD = 3'h7
    } eec_op_type;

    // sequencer states
    typedef enum logic [2:0] {
        EEC_ST_IDLE,
        EEC_ST_SELECT,
        EEC_ST_SHIFT,
        EEC_ST_END,
        EEC_ST_RDY_SEL,
        EEC_ST_RDY_WAIT
    } eec_state_type;
endpackage

// File: verification/eec_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// serial memory partner: 512 bytes, powers up write-protected
// ------------------------------------------------------------
module eec_mem_model (
    input wire logic clk_i,
    input wire logic sel_i,
    input wire logic sk_i,
    input wire logic di_i,
    input wire logic mute_i,
    output logic do_o
);
    logic [7:0] mem [512]; // erased state is all ones
    logic [19:0] sr_q; // bits shifted in this frame
    logic [11:0] hdr_q; // start, opcode, address
    logic sk_q, sel_q, drv_q, rd_q, tog_q, wen_q;
    int cnt_q, busy_q;
    wire [1:0] op = hdr_q[10:9];
    wire [8:0] adr = hdr_q[8:0];
    // write class: write, erase, or misc write-all / erase-all
    wire wcls = op == 2'h1 || op == 2'h3 || (op == 2'h0 && adr[8] != adr[7]);
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        mem[0] = 8'hA5;
        {sr_q, hdr_q, sk_q, sel_q, drv_q, rd_q, tog_q, wen_q} = '0;
        cnt_q = 0;
        busy_q = 0;
    end
    // released line toggles, so a stale sample never looks valid
    assign do_o = mute_i ? 1'b0 : drv_q ? rd_q : sel_i ? busy_q == 0 : tog_q;
    always @(posedge clk_i) begin
        sk_q <= sk_i;
        sel_q <= sel_i;
        tog_q <= !tog_q;
        if (busy_q > 0) busy_q <= busy_q - 1;
        // leading zeros before the start bit are ignored
        if (sel_i && sk_i && !sk_q && (cnt_q > 0 || di_i)) begin
            sr_q <= {sr_q[18:0], di_i};
            cnt_q <= cnt_q + 1;
            if (cnt_q == 11) hdr_q <= {sr_q[10:0], di_i};
            drv_q <= cnt_q >= 12 && op == 2'h2;
            rd_q <= mem[adr][19 - cnt_q];
        end
        if (sel_q && !sel_i) begin
            cnt_q <= 0;
            drv_q <= 1'b0;
            if (cnt_q >= 12 && op == 2'h0 && adr[8:7] == 2'h3) wen_q <= 1'b1;
            if (cnt_q >= 12 && op == 2'h0 && adr[8:7] == 2'h0) wen_q <= 1'b0;
            if (cnt_q >= 12 && wen_q && wcls) begin
                busy_q <= 60;
                foreach (mem[i]) if (i == adr || (op == 2'h0 && adr[8] != adr[7]))
                    mem[i] <= (op == 2'h3 || (op == 2'h0 && adr[8])) ? 8'hFF : sr_q[7:0];
            end
        end
    end
endmodule

// File: verification/tb_eec_ctrl.sv
`timescale 1ns/1ps
module tb_eec_ctrl;
    import eec_pkg::*;
    localparam logic [11:0] CTL = 12'h030;
    localparam logic [11:0] DAT = 12'h034;
    logic clk_i = 1'b0, reset_i = 1'b1, mute = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, sel, sk, sdo, sdi;
    logic [1:0] bresp, rresp, r;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    always #2.5 clk_i = !clk_i;
    // short no-response limit keeps the time-out case brief
    eec_ctrl #(.NORESP_CYCLES(200)) i_dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .ee_select_o(sel), .ee_clock_o(sk), .ee_data_out_o(sdo),
        .eeprom_serial_in_i(sdi));
    eec_mem_model i_mem (.clk_i(clk_i), .sel_i(sel), .sk_i(sk), .di_i(sdo), .mute_i(mute), .do_o(sdi));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // each channel released at its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic run(input eec_op_type op, input logic [8:0] p, input logic [7:0] d);
        wr(DAT, {24'h0, d});
        wr(CTL, {1'b1, op, 19'h0, p});
        do rd(CTL); while (v[31] !== 1'b0);
    endtask
    // data is cleared first so a stale byte cannot pass
    task automatic rdb(input logic [8:0] p, input logic [7:0] e, input string n);
        run(EEC_OP_READ, p, 8'h00);
        rd(DAT);
        chk(n, {24'h0, e}, v);
    endtask
    task automatic t_reset;
        rd(CTL);
        chk("control after reset", 32'hF000_0000, v);
        do rd(CTL); while (v[31] !== 1'b0);
        chk("control after boot", 32'h7000_0200, v);
        rd(12'h038);
        chk("unmapped resp", 32'h2, {30'h0, r});
        wr(12'h038, 32'h0);
        chk("unmapped write resp", 32'h2, {30'h0, r});
        $display("test reset done");
    endtask
    task automatic t_ops;
        run(EEC_OP_WRITE, 9'h005, 8'h3C);
        rdb(9'h005, 8'hFF, "protected write");
        run(EEC_OP_ERASE_WRITE_ENABLE, 9'h000, 8'h00);
        run(EEC_OP_WRITE, 9'h1FF, 8'h3C);
        rdb(9'h1FF, 8'h3C, "write then read");
        run(EEC_OP_ERASE, 9'h1FF, 8'h00);
        rdb(9'h1FF, 8'hFF, "erase");
        run(EEC_OP_ERASE_WRITE_DISABLE, 9'h000, 8'h00);
        run(EEC_OP_WRITE, 9'h1FF, 8'h11);
        rdb(9'h1FF, 8'hFF, "disabled write");
        $display("test single ops done");
    endtask
    task automatic t_all;
        run(EEC_OP_ERASE_WRITE_ENABLE, 9'h000, 8'h00);
        run(EEC_OP_WRITE_ALL_LOCATIONS, 9'h000, 8'h66);
        rdb(9'h100, 8'h66, "write all");
        run(EEC_OP_ERASE_ALL_LOCATIONS, 9'h000, 8'h00);
        rdb(9'h0AA, 8'hFF, "erase all");
        $display("test bulk ops done");
    endtask
    // marker is gone after the bulk erase: a mid-run reset boots blank, the first reload fails
    task automatic t_reload;
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        do rd(CTL); while (v[31] !== 1'b0);
        chk("loaded after blank boot", 32'h0, v & 32'h200);
        run(EEC_OP_RELOAD, 9'h000, 8'h5A);
        chk("loaded after failed reload", 32'h0, v & 32'h200);
        rd(DAT);
        chk("data after failed reload", 32'h5A, v);
        run(EEC_OP_WRITE, 9'h000, 8'hA5);
        run(EEC_OP_RELOAD, 9'h000, 8'h00);
        chk("loaded after reload", 32'h200, v & 32'h200);
        $display("test reload done");
    endtask
    task automatic t_timeout;
        @(posedge clk_i);
        mute <= 1'b1;
        run(EEC_OP_READ, 9'h003, 8'h00);
        chk("read no time-out", 32'h0, v & 32'h400);
        run(EEC_OP_WRITE, 9'h003, 8'h00);
        chk("write time-out", 32'h400, v & 32'h400);
        wr(CTL, 32'h0000_0400);
        rd(CTL);
        chk("flag cleared", 32'h0, v & 32'h400);
        $display("test time-out done");
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_ops;
        t_all;
        t_reload;
        t_timeout;
        finish_test;
    end
    // hang guard sized for about twenty serial operations
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 99000) begin
            fail_count++;
            finish_test;
        end
    end
endmodule
